/* pkg/dual_timer_defines.vh */
/*
 * Register map, field positions and reset values of the dual 8-bit
 * compare timer. Assumes an 8-bit peripheral bus with 16-bit byte addresses.
 */
`ifndef DUAL_TIMER_DEFINES_VH
`define DUAL_TIMER_DEFINES_VH

// Register byte addresses
`define ADDR_TIMER_CONTROL        16'hffb6
`define ADDR_TIMER_STATUS_CONTROL 16'hffb7
`define ADDR_COUNTER_UPPER_BYTE   16'hffb8
`define ADDR_COUNTER_LOWER_BYTE   16'hffb9
`define ADDR_COMPARE_UPPER_BYTE   16'hffba
`define ADDR_COMPARE_LOWER_BYTE   16'hffbb
`define ADDR_MODULE_CLOCK_STOP    16'hfffa

// Reset values
`define RST_TIMER_CONTROL         8'h00
`define RST_TIMER_STATUS_CONTROL  8'h00
`define RST_COUNTER               8'h00
`define RST_COMPARE               8'hff
`define RST_MODULE_CLOCK_STOP     8'hff
`define READ_UNMAPPED             8'hff

// timer_control fields
`define CTRL_TOGGLE_LEVEL_HIGH    7
`define CTRL_HIGH_SEL_MSB         6
`define CTRL_HIGH_SEL_LSB         4
`define CTRL_TOGGLE_LEVEL_LOW     3
`define CTRL_LOW_SEL_MSB          2
`define CTRL_LOW_SEL_LSB          0

// timer_status_control fields
`define ST_OVERFLOW_FLAG_HIGH     7
`define ST_COMPARE_FLAG_HIGH      6
`define ST_OVERFLOW_IRQ_EN_HIGH   5
`define ST_COUNTER_CLEAR_HIGH     4
`define ST_OVERFLOW_FLAG_LOW      3
`define ST_COMPARE_FLAG_LOW       2
`define ST_OVERFLOW_IRQ_EN_LOW    1
`define ST_COUNTER_CLEAR_LOW      0
`define ST_FLAG_MASK              8'hcc

// module_clock_stop: this timer runs while the bit is 1
`define STOP_TIMER_RUN_BIT        2

// Clock select codes (msb set selects an internal tick)
`define SEL_DIV32                 3'h4
`define SEL_DIV16                 3'h5
`define SEL_DIV4                  3'h6
`define SEL_SUB_DIV4              3'h7

`endif

/* src/dual_8bit_compare_timer.v */
/*
 * 16-bit compare timer that splits into two 8-bit timers, with its
 * CPU-side byte registers. Assumes prescaler strobes one sys_clk cycle wide
 * and an interrupt controller that latches the pending-set pulses.
 */
// What this block does
// R1 - Two cascaded 8-bit counters form one 16-bit counter, or run apart.
// R2 - Reset loads both counter halves with zero.
// R3 - High select msb 0 gives 16-bit mode clocked by low select.
// R4 - 16-bit wrap sets high overflow flag, and pending if enabled.
// R5 - High select msb 1 gives two 8-bit counters, each own select.
// R6 - In 8-bit mode each half wrap sets its flag and pending if enabled.
// R7 - Match clears counter only with its clear bit; 16-bit uses high bit.
// R8 - Reset loads both compare bytes with 0xff.
// R9 - 16-bit compare equality sets high compare flag and high pending.
// R10 - 8-bit mode compares each half, sets its flag and pending.
// R11 - Match toggles high output; low output toggles on low matches.
// R12 - Control level bits drive the toggle pins at once; reset low.
// R13 - Control register is write-only, resets to zero, fixed layout.
// R14 - High select 0xx is 16-bit; 100..111 pick div32, div16, div4, sub.
// R15 - Low select 0xx counts event pin edges; 100..111 internal ticks.
// R16 - Event pin feeds only the low half; edge chosen externally.
// R17 - Software expects a spurious count when pin function turns on low.
// R18 - Status flags accept only zero writes; other status bits are read/write.
// R19 - Status register resets to zero with the fixed bit layout.
// R20 - A flag clears only by a zero write after reading it as one.
// R21 - 16-bit accesses go through a holding byte, upper byte first.
// R22 - Each clock source is a one-cycle strobe; in 16-bit mode low overflow clocks high.
`timescale 1ns/1ps
`default_nettype none
`include "dual_timer_defines.vh"

module dual_8bit_compare_timer #(
    parameter DW = 8
) (
    input  wire          sys_clk,
    input  wire          rst,
    input  wire [15:0]   bus_addr,
    input  wire [DW-1:0] bus_wdata,
    input  wire          bus_wr,
    input  wire          bus_rd,
    output reg  [DW-1:0] bus_rdata,
    input  wire          tick_div32,
    input  wire          tick_div16,
    input  wire          tick_div4,
    input  wire          sub_clk_div4,
    input  wire          event_input,
    input  wire          event_edge_select,
    input  wire          event_pin_function_bit,
    output reg           toggle_out_high,
    output reg           toggle_out_low,
    output reg           irq_pending_high,
    output reg           irq_pending_low
);

    ////////////////////////////////////////////////////////////////////////
    // Clock select decode shared by both halves
    function pick_tick;
        input [2:0] sel;
        input       alt;
        input       t32;
        input       t16;
        input       t4;
        input       tw4;
        begin
            case (sel)
                `SEL_DIV32:    pick_tick = t32;
                `SEL_DIV16:    pick_tick = t16;
                `SEL_DIV4:     pick_tick = t4;
                `SEL_SUB_DIV4: pick_tick = tw4;
                default:       pick_tick = alt;
            endcase
        end
    endfunction

    // Register state
    reg  [DW-1:0] timer_control_r;
    reg  [DW-1:0] status_r;
    reg  [DW-1:0] status_nxt;
    reg  [DW-1:0] armed_r;
    reg  [DW-1:0] armed_nxt;
    reg  [DW-1:0] counter_high_r;
    reg  [DW-1:0] counter_low_r;
    reg  [DW-1:0] counter_high_nxt;
    reg  [DW-1:0] counter_low_nxt;
    reg  [DW-1:0] compare_high_r;
    reg  [DW-1:0] compare_low_r;
    reg  [DW-1:0] clock_stop_r;
    reg  [DW-1:0] hold_r;
    reg           match_high_prev_r;
    reg           match_low_prev_r;

    wire          event_tick;
    wire          sub_tick;
    wire          pin_level;
    wire [2:0]    high_sel;
    wire [2:0]    low_sel;
    wire          mode8;
    wire          running;

    ////////////////////////////////////////////////////////////////////////
    // Bus decode
    wire wr_ctrl  = bus_wr & (bus_addr == `ADDR_TIMER_CONTROL);
    wire wr_stat  = bus_wr & (bus_addr == `ADDR_TIMER_STATUS_CONTROL);
    wire wr_cnt_h = bus_wr & (bus_addr == `ADDR_COUNTER_UPPER_BYTE);
    wire wr_cnt_l = bus_wr & (bus_addr == `ADDR_COUNTER_LOWER_BYTE);
    wire wr_cmp_h = bus_wr & (bus_addr == `ADDR_COMPARE_UPPER_BYTE);
    wire wr_cmp_l = bus_wr & (bus_addr == `ADDR_COMPARE_LOWER_BYTE);
    wire wr_stop  = bus_wr & (bus_addr == `ADDR_MODULE_CLOCK_STOP);
    wire rd_stat  = bus_rd & (bus_addr == `ADDR_TIMER_STATUS_CONTROL);
    wire rd_cnt_h = bus_rd & (bus_addr == `ADDR_COUNTER_UPPER_BYTE);

    ////////////////////////////////////////////////////////////////////////
    // Mode and clock source selection
    assign high_sel = timer_control_r[`CTRL_HIGH_SEL_MSB:`CTRL_HIGH_SEL_LSB];
    assign low_sel  = timer_control_r[`CTRL_LOW_SEL_MSB:`CTRL_LOW_SEL_LSB];
    assign mode8    = timer_control_r[`CTRL_HIGH_SEL_MSB]; // R3 R5
    assign running  = clock_stop_r[`STOP_TIMER_RUN_BIT];

    // Pin reads high while its function is off, so enabling it low counts when falling edges are selected
    assign pin_level = event_pin_function_bit ? event_input : 1'b1; // R17

    timer_tick_source u_tick_source (
        .sys_clk      (sys_clk),
        .rst          (rst),
        .pin_level    (pin_level),
        .edge_rising  (event_edge_select),
        .sub_clk_div4 (sub_clk_div4),
        .event_tick   (event_tick),
        .sub_tick     (sub_tick)
    );

    // Count strobes of each half
    wire low_tick = running & pick_tick(low_sel, event_tick, tick_div32,
                                        tick_div16, tick_div4, sub_tick); // R15 R16
    wire low_wrap = low_tick & (counter_low_r == 8'hff);
    wire high_tick = mode8
        ? running & pick_tick(high_sel, 1'b0, tick_div32,
                              tick_div16, tick_div4, sub_tick) // R14 R5
        : low_wrap; // R22 R3 R1
    wire high_wrap = high_tick & (counter_high_r == 8'hff);

    ////////////////////////////////////////////////////////////////////////
    // Compare matches, each counted once on the cycle equality begins
    wire match16 = ({counter_high_r, counter_low_r} ==
                    {compare_high_r, compare_low_r}); // R9
    wire match_high_now = mode8 ? (counter_high_r == compare_high_r) : match16; // R10
    wire match_low_now  = mode8 & (counter_low_r == compare_low_r); // R10
    wire match_high = match_high_now & ~match_high_prev_r;
    wire match_low  = match_low_now & ~match_low_prev_r;

    wire clr_high = status_r[`ST_COUNTER_CLEAR_HIGH];
    wire clr_low  = status_r[`ST_COUNTER_CLEAR_LOW];
    wire ovf_high_set = high_wrap; // R4 R6
    wire ovf_low_set  = mode8 & low_wrap; // R6

    always @(posedge sys_clk) begin
        if (rst) begin
            match_high_prev_r <= 1'b0;
            match_low_prev_r  <= 1'b0;
        end else begin
            match_high_prev_r <= match_high_now;
            match_low_prev_r  <= match_low_now;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Counter next value: CPU write, then match clear, then count
    always @* begin
        counter_low_nxt  = counter_low_r + {{(DW-1){1'b0}}, low_tick};
        counter_high_nxt = counter_high_r + {{(DW-1){1'b0}}, high_tick};
        if (mode8) begin
            if (match_low & clr_low)
                counter_low_nxt = `RST_COUNTER; // R7
            if (match_high & clr_high)
                counter_high_nxt = `RST_COUNTER; // R7
        end else if (match_high & clr_high) begin
            counter_low_nxt  = `RST_COUNTER; // R7
            counter_high_nxt = `RST_COUNTER; // R7
        end
        if (mode8) begin
            if (wr_cnt_h)
                counter_high_nxt = bus_wdata;
            if (wr_cnt_l)
                counter_low_nxt = bus_wdata;
        end else if (wr_cnt_l) begin
            counter_high_nxt = hold_r; // R21
            counter_low_nxt  = bus_wdata; // R21
        end
    end

    always @(posedge sys_clk) begin
        if (rst) begin
            counter_high_r <= `RST_COUNTER; // R2
            counter_low_r  <= `RST_COUNTER; // R2
        end else begin
            counter_high_r <= counter_high_nxt;
            counter_low_r  <= counter_low_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Compare registers, holding byte and control registers
    always @(posedge sys_clk) begin
        if (rst) begin
            compare_high_r  <= `RST_COMPARE; // R8
            compare_low_r   <= `RST_COMPARE; // R8
            hold_r          <= 8'h00;
            timer_control_r <= `RST_TIMER_CONTROL; // R13
            clock_stop_r    <= `RST_MODULE_CLOCK_STOP;
        end else begin
            if (wr_cmp_h & mode8)
                compare_high_r <= bus_wdata;
            if (wr_cmp_l & mode8)
                compare_low_r <= bus_wdata;
            if (wr_cmp_l & ~mode8) begin
                compare_high_r <= hold_r; // R21
                compare_low_r  <= bus_wdata; // R21
            end
            // Upper-byte write parks data; upper counter read latches low
            if (~mode8 & (wr_cnt_h | wr_cmp_h))
                hold_r <= bus_wdata; // R21
            else if (~mode8 & rd_cnt_h)
                hold_r <= counter_low_r; // R21
            if (wr_ctrl)
                timer_control_r <= bus_wdata; // R13
            if (wr_stop)
                clock_stop_r <= bus_wdata;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Status flags: hardware set wins over a software clear
    wire [DW-1:0] flag_set = {ovf_high_set, match_high, 2'b00,
                              ovf_low_set, match_low, 2'b00}; // R9 R10
    wire [DW-1:0] flag_clr = (wr_stat ? ~bus_wdata : 8'h00) & armed_r
                             & `ST_FLAG_MASK; // R18 R20

    always @* begin
        status_nxt = (status_r & ~flag_clr & `ST_FLAG_MASK) | flag_set; // R18 R20
        if (wr_stat)
            status_nxt = status_nxt | (bus_wdata & ~`ST_FLAG_MASK); // R18
        else
            status_nxt = status_nxt | (status_r & ~`ST_FLAG_MASK);
        armed_nxt = armed_r & ~flag_clr;
        if (rd_stat)
            armed_nxt = armed_nxt | (status_r & `ST_FLAG_MASK); // R20
    end

    always @(posedge sys_clk) begin
        if (rst) begin
            status_r <= `RST_TIMER_STATUS_CONTROL; // R19
            armed_r  <= 8'h00;
        end else begin
            status_r <= status_nxt;
            armed_r  <= armed_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Interrupt pending set pulses to the interrupt controller
    always @(posedge sys_clk) begin
        if (rst) begin
            irq_pending_high <= 1'b0;
            irq_pending_low  <= 1'b0;
        end else begin
            irq_pending_high <= match_high
                | (ovf_high_set & status_r[`ST_OVERFLOW_IRQ_EN_HIGH]); // R4 R9
            irq_pending_low  <= match_low
                | (ovf_low_set & status_r[`ST_OVERFLOW_IRQ_EN_LOW]); // R6 R10
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Toggle outputs: level write takes priority over a match
    always @(posedge sys_clk) begin
        if (rst) begin
            toggle_out_high <= 1'b0; // R12
            toggle_out_low  <= 1'b0; // R12
        end else begin
            if (wr_ctrl)
                toggle_out_high <= bus_wdata[`CTRL_TOGGLE_LEVEL_HIGH]; // R12
            else if (match_high)
                toggle_out_high <= ~toggle_out_high; // R11
            if (wr_ctrl)
                toggle_out_low <= bus_wdata[`CTRL_TOGGLE_LEVEL_LOW]; // R12
            else if (match_low)
                toggle_out_low <= ~toggle_out_low; // R11
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read data, registered; control register reads as unmapped
    always @(posedge sys_clk) begin
        if (rst) begin
            bus_rdata <= 8'h00;
        end else if (bus_rd) begin
            case (bus_addr)
                `ADDR_TIMER_STATUS_CONTROL: bus_rdata <= status_r;
                `ADDR_COUNTER_UPPER_BYTE:   bus_rdata <= counter_high_r;
                `ADDR_COUNTER_LOWER_BYTE:   bus_rdata <= mode8 ? counter_low_r
                                                               : hold_r; // R21
                `ADDR_COMPARE_UPPER_BYTE:   bus_rdata <= compare_high_r;
                `ADDR_COMPARE_LOWER_BYTE:   bus_rdata <= compare_low_r;
                `ADDR_MODULE_CLOCK_STOP:    bus_rdata <= clock_stop_r;
                default:                    bus_rdata <= `READ_UNMAPPED; // R13
            endcase
        end
    end

endmodule // dual_8bit_compare_timer

`default_nettype wire

/* src/timer_tick_source.v */
/*
 * Turns the event pin and the sub-clock into one-cycle count strobes.
 * Assumes both inputs may be asynchronous to sys_clk; two flops each.
 */
`timescale 1ns/1ps
`default_nettype none

module timer_tick_source (
    input  wire       sys_clk,
    input  wire       rst,
    input  wire       pin_level,
    input  wire       edge_rising,
    input  wire       sub_clk_div4,
    output reg        event_tick,
    output reg        sub_tick
);

    reg  [1:0] pin_sync_r;
    reg        pin_prev_r;
    reg  [1:0] sub_sync_r;
    reg        sub_prev_r;

    ////////////////////////////////////////////////////////////////////////
    // Synchronisers; first stage feeds only the second
    always @(posedge sys_clk) begin
        if (rst) begin
            pin_sync_r <= 2'h3;
            pin_prev_r <= 1'b1;
            sub_sync_r <= 2'h0;
            sub_prev_r <= 1'b0;
        end else begin
            pin_sync_r <= {pin_sync_r[0], pin_level};
            pin_prev_r <= pin_sync_r[1];
            sub_sync_r <= {sub_sync_r[0], sub_clk_div4};
            sub_prev_r <= sub_sync_r[1];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Edge strobes, one sys_clk cycle each
    always @(posedge sys_clk) begin
        if (rst) begin
            event_tick <= 1'b0;
            sub_tick   <= 1'b0;
        end else begin
            event_tick <= edge_rising ? (pin_sync_r[1] & ~pin_prev_r)  // R16
                                      : (~pin_sync_r[1] & pin_prev_r); // R16
            sub_tick   <= sub_sync_r[1] & ~sub_prev_r; // R22
        end
    end

endmodule // timer_tick_source

`default_nettype wire

/* tb/cpu_bus_model.sv */
/* CPU side of the 8-bit peripheral bus: byte write and read tasks.
   Assumes requests launch at the falling edge and are taken on the rising. */
`timescale 1ns/1ps
`default_nettype none
module cpu_bus_model (
    input  wire logic        sys_clk,
    input  wire logic [7:0]  bus_rdata,
    output var  logic [15:0] bus_addr,
    output var  logic [7:0]  bus_wdata,
    output var  logic        bus_wr,
    output var  logic        bus_rd
);
    // Idle bus
    initial begin
        bus_addr = 16'h0000;
        bus_wdata = 8'h00;
        bus_wr = 1'b0;
        bus_rd = 1'b0;
    end
    // One byte write, strobe one cycle, stale lines inverted after
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(negedge sys_clk);
        bus_addr = a;
        bus_wdata = d;
        bus_wr = 1'b1;
        @(negedge sys_clk);
        bus_wr = 1'b0;
        bus_addr = ~a;
        bus_wdata = ~d;
    endtask
    // One byte read; registered data settled by the next falling edge
    task automatic rd(input logic [15:0] a, output logic [7:0] d);
        @(negedge sys_clk);
        bus_addr = a;
        bus_rd = 1'b1;
        @(negedge sys_clk);
        bus_rd = 1'b0;
        bus_addr = ~a;
        d = bus_rdata;
    endtask
endmodule // cpu_bus_model
`default_nettype wire

/* tb/dual_8bit_compare_timer_tb.sv */
/* Self-checking bench for the dual 8-bit compare timer.
   Assumes the CPU bus model and the register map header. */
`timescale 1ns/1ps
`default_nettype none
`include "dual_timer_defines.vh"
module dual_8bit_compare_timer_tb;
    logic        sys_clk, rst, bus_wr, bus_rd;
    logic [15:0] bus_addr, v16, ca;
    logic [7:0]  bus_wdata, bus_rdata, rd_v;
    logic        tick_div32, tick_div16, tick_div4, sub_clk_div4;
    logic        event_input, event_edge_select, event_pin_function_bit;
    logic        toggle_out_high, toggle_out_low, irq_pending_high, irq_pending_low;
    logic [2:0]  code;
    int          n_fail, n_compared, seed, cycles, n_irq_h, n_irq_l, n;
    cpu_bus_model cpu (.sys_clk, .bus_rdata, .bus_addr, .bus_wdata, .bus_wr, .bus_rd);
    dual_8bit_compare_timer #(.DW(8)) dut (.sys_clk, .rst, .bus_addr, .bus_wdata, .bus_wr,
        .bus_rd, .bus_rdata, .tick_div32, .tick_div16, .tick_div4, .sub_clk_div4,
        .event_input, .event_edge_select, .event_pin_function_bit, .toggle_out_high,
        .toggle_out_low, .irq_pending_high, .irq_pending_low);
    initial begin
        sys_clk = 1'b0;
        forever #50 sys_clk = ~sys_clk;
    end
    // Pulse counting and hang guard
    always @(negedge sys_clk) begin
        cycles++;
        if (irq_pending_high === 1'b1) n_irq_h++;
        if (irq_pending_low === 1'b1) n_irq_l++;
        if (cycles >= 20000) begin
            n_fail++;
            report_and_stop();
        end
    end
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_fail++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic rd_chk(input logic [15:0] a, input logic [7:0] exp);
        cpu.rd(a, rd_v);
        chk(16'(rd_v), 16'(exp));
    endtask
    // Upper byte first, as the holding byte needs
    task automatic wr16(input logic [15:0] a, input logic [15:0] v);
        cpu.wr(a, v[15:8]);
        cpu.wr(a + 16'h1, v[7:0]);
    endtask
    task automatic rd16_chk(input logic [15:0] a, input logic [15:0] exp);
        logic [7:0] hi;
        cpu.rd(a, hi);
        cpu.rd(a + 16'h1, rd_v);
        chk({hi, rd_v}, exp);
    endtask
    // One count from the source a select code names, then settle
    task automatic pulse(input logic [2:0] c);
        @(negedge sys_clk);
        case (c)
            3'h4: tick_div32 = 1'b1;
            3'h5: tick_div16 = 1'b1;
            3'h6: tick_div4 = 1'b1;
            3'h7: sub_clk_div4 = 1'b1;
            default: event_input = 1'b0;
        endcase
        @(negedge sys_clk);
        {tick_div32, tick_div16, tick_div4} = 3'h0;
        repeat (4) @(negedge sys_clk);
        sub_clk_div4 = 1'b0;
        event_input = 1'b1;
        repeat (($random(seed) & 3) + 4) @(negedge sys_clk);
    endtask
    task automatic report_and_stop();
        $display("compared %0d, mismatches %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    // Main sequence
    initial begin
        seed = 77800;
        rst = 1'b1;
        {tick_div32, tick_div16, tick_div4, sub_clk_div4} = 4'h0;
        {event_input, event_edge_select, event_pin_function_bit} = 3'b110;
        repeat (5) @(negedge sys_clk);
        rst = 1'b0;
        rd_chk(`ADDR_TIMER_STATUS_CONTROL, 8'h00);
        rd_chk(`ADDR_COMPARE_UPPER_BYTE, 8'hff);
        rd_chk(`ADDR_COMPARE_LOWER_BYTE, 8'hff);
        rd16_chk(`ADDR_COUNTER_UPPER_BYTE, 16'h0000);
        rd_chk(`ADDR_TIMER_CONTROL, 8'hff);
        rd_chk(16'hffbc, 8'hff);
        $display("test reset_values done");
        v16 = 16'($random(seed));
        wr16(`ADDR_COUNTER_UPPER_BYTE, v16);
        rd16_chk(`ADDR_COUNTER_UPPER_BYTE, v16);
        wr16(`ADDR_COMPARE_UPPER_BYTE, ~v16);
        rd16_chk(`ADDR_COMPARE_UPPER_BYTE, ~v16);
        cpu.wr(`ADDR_TIMER_CONTROL, 8'h88);
        chk(16'({toggle_out_high, toggle_out_low}), 16'h3);
        $display("test pairing_levels done");
        // Pin function turned on while the pin is high: no stray count
        event_pin_function_bit = 1'b1;
        cpu.wr(`ADDR_TIMER_CONTROL, 8'h06);
        cpu.wr(`ADDR_TIMER_STATUS_CONTROL, 8'h10);
        wr16(`ADDR_COMPARE_UPPER_BYTE, 16'h0003);
        wr16(`ADDR_COUNTER_UPPER_BYTE, 16'h0000);
        n_irq_h = 0;
        repeat (3) pulse(3'h6);
        chk(16'(n_irq_h), 16'h1);
        chk(16'(toggle_out_high), 16'h1);
        rd16_chk(`ADDR_COUNTER_UPPER_BYTE, 16'h0000);
        rd_chk(`ADDR_TIMER_STATUS_CONTROL, 8'h50);
        cpu.wr(`ADDR_TIMER_STATUS_CONTROL, 8'hd0);
        rd_chk(`ADDR_TIMER_STATUS_CONTROL, 8'h50);
        cpu.wr(`ADDR_TIMER_STATUS_CONTROL, 8'h10);
        rd_chk(`ADDR_TIMER_STATUS_CONTROL, 8'h10);
        $display("test match16 done");
        cpu.wr(`ADDR_TIMER_CONTROL, 8'h05);
        cpu.wr(`ADDR_TIMER_STATUS_CONTROL, 8'h20);
        wr16(`ADDR_COMPARE_UPPER_BYTE, 16'h8000);
        wr16(`ADDR_COUNTER_UPPER_BYTE, 16'hfffe);
        n_irq_h = 0;
        repeat (2) pulse(3'h5);
        chk(16'(n_irq_h), 16'h1);
        rd16_chk(`ADDR_COUNTER_UPPER_BYTE, 16'h0000);
        // Zero write to an unread flag must leave it set
        cpu.wr(`ADDR_TIMER_STATUS_CONTROL, 8'h20);
        rd_chk(`ADDR_TIMER_STATUS_CONTROL, 8'ha0);
        wr16(`ADDR_COMPARE_UPPER_BYTE, 16'hffff);
        $display("test overflow16 done");
        // Every low select code, then the high half's internal-tick codes 100..111
        for (int c = 0; c < 12; c++) begin
            code = (c < 8) ? 3'(c) : 3'(c) | 3'h4;
            ca = (c < 8) ? `ADDR_COUNTER_LOWER_BYTE : `ADDR_COUNTER_UPPER_BYTE;
            cpu.wr(`ADDR_TIMER_CONTROL, (c < 8) ? {4'h4, 1'b0, code} : {1'b0, code, 4'h0});
            cpu.wr(ca, 8'h00);
            event_edge_select = (c != 1) && (c != 3);
            n = ($random(seed) & 3) + 1;
            repeat (n) pulse(code);
            rd_chk(ca, 8'(n));
        end
        $display("test select_codes done");
        cpu.wr(`ADDR_TIMER_CONTROL, 8'h46);
        cpu.wr(`ADDR_TIMER_STATUS_CONTROL, 8'h23);
        // Low half cleared first so the new compare cannot match early
        cpu.wr(`ADDR_COUNTER_LOWER_BYTE, 8'h00);
        cpu.wr(`ADDR_COMPARE_LOWER_BYTE, 8'h02);
        cpu.wr(`ADDR_COMPARE_UPPER_BYTE, 8'h80);
        cpu.wr(`ADDR_COUNTER_UPPER_BYTE, 8'hff);
        {n_irq_h, n_irq_l} = 0;
        repeat (2) pulse(3'h6);
        pulse(3'h4);
        chk(16'(n_irq_l), 16'h1);
        chk(16'(n_irq_h), 16'h1);
        chk(16'(toggle_out_low), 16'h1);
        rd_chk(`ADDR_COUNTER_LOWER_BYTE, 8'h00);
        rd_chk(`ADDR_TIMER_STATUS_CONTROL, 8'ha7);
        $display("test split8 done");
        // Stopped module ignores ticks, registers stay reachable
        cpu.wr(`ADDR_MODULE_CLOCK_STOP, 8'hfb);
        pulse(3'h6);
        rd_chk(`ADDR_MODULE_CLOCK_STOP, 8'hfb);
        rd_chk(`ADDR_COUNTER_LOWER_BYTE, 8'h00);
        $display("test clock_stop done");
        report_and_stop();
    end
endmodule // dual_8bit_compare_timer_tb
bind dual_8bit_compare_timer timer_asserts #(.DW(DW)) chk_u (.sys_clk, .rst, .bus_addr,
    .bus_wdata, .bus_wr, .bus_rd, .bus_rdata, .toggle_out_high, .toggle_out_low,
    .irq_pending_high, .irq_pending_low);
`default_nettype wire

/* tb/timer_asserts.sv */
/* Port-level concurrent checks for the dual 8-bit compare timer.
   Assumes one clock domain and a synchronous active-high reset. */
`timescale 1ns/1ps
`default_nettype none
`include "dual_timer_defines.vh"
module timer_asserts #(
    parameter DW = 8
) (
    input wire logic          sys_clk,
    input wire logic          rst,
    input wire logic [15:0]   bus_addr,
    input wire logic [DW-1:0] bus_wdata,
    input wire logic          bus_wr,
    input wire logic          bus_rd,
    input wire logic [DW-1:0] bus_rdata,
    input wire logic          toggle_out_high,
    input wire logic          toggle_out_low,
    input wire logic          irq_pending_high,
    input wire logic          irq_pending_low
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);
    logic ctrl_wr;
    logic mode_8bit_r;
    logic hi_seen_r;
    assign ctrl_wr = bus_wr && bus_addr == `ADDR_TIMER_CONTROL;
    // Shadow of mode bit and of a high event not yet followed by a status write
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            mode_8bit_r <= 1'b0;
            hi_seen_r <= 1'b0;
        end else begin
            if (ctrl_wr) mode_8bit_r <= bus_wdata[6];
            if (irq_pending_high) hi_seen_r <= 1'b1;
            else if (bus_wr && bus_addr == `ADDR_TIMER_STATUS_CONTROL) hi_seen_r <= 1'b0;
        end
    end
    sequence s_status_rd;
        bus_rd && bus_addr == `ADDR_TIMER_STATUS_CONTROL;
    endsequence
    sequence s_dead_rd;
        bus_rd && bus_addr != `ADDR_TIMER_STATUS_CONTROL && bus_addr != `ADDR_MODULE_CLOCK_STOP
            && (bus_addr < `ADDR_COUNTER_UPPER_BYTE || bus_addr > `ADDR_COMPARE_LOWER_BYTE);
    endsequence
    chk_reset_quiet: assert property (
        $fell(rst) |-> !toggle_out_high && !toggle_out_low && !irq_pending_high
            && !irq_pending_low && bus_rdata == 8'h00) else $error("outputs not idle after reset");
    chk_level_high: assert property (
        ctrl_wr |=> toggle_out_high == $past(bus_wdata[7])) else $error("high level not applied");
    chk_level_low: assert property (
        ctrl_wr |=> toggle_out_low == $past(bus_wdata[3])) else $error("low level not applied");
    chk_toggle_cause: assert property (
        $changed(toggle_out_high) |-> irq_pending_high || $past(ctrl_wr))
        else $error("high toggle without match");
    chk_dead_read_ff: assert property (
        s_dead_rd |=> bus_rdata == 8'hff) else $error("write-only or unmapped read not ff");
    chk_rdata_stands: assert property (
        !bus_rd |=> $stable(bus_rdata)) else $error("read data moved without a read");
    chk_low_quiet_16: assert property (
        !mode_8bit_r && !$past(mode_8bit_r) |-> !irq_pending_low)
        else $error("low event in 16-bit mode");
    chk_flag_high_read: assert property (
        hi_seen_r ##0 s_status_rd |=> (bus_rdata[7] || bus_rdata[6]))
        else $error("high event without status flag");
endmodule // timer_asserts
`default_nettype wire
